// >>> logic/tsar_pkg.sv
// Constants and types of the Type-C state and measurement readout block
package tsar_pkg;
  localparam logic [7:0] OFS_PORT_STATE = 8'h0E;
  localparam logic [7:0] OFS_LOAD_CURRENT = 8'h10;
  localparam logic [7:0] OFS_BUS_VOLTAGE = 8'h11;
  localparam logic [7:0] OFS_DIE_TEMP = 8'h12;
  localparam logic [7:0] OFS_FREQ_CTRL = 8'h20;
  localparam int ORIENT_LSB = 4;
  localparam int ROLE_LSB = 0;
  localparam int FREQ_OVR_BIT = 7;
  localparam int FREQ_W = 4;
  localparam logic [1:0] ORIENT_NONE = 2'h0;
  localparam logic [1:0] ORIENT_CC1 = 2'h1;
  localparam logic [1:0] ORIENT_CC2 = 2'h2;
  localparam logic [3:0] ROLE_DISABLED = 4'h0;
  localparam logic [3:0] ROLE_ERR_RECOV = 4'h2;
  localparam logic [3:0] ROLE_UNATTACHED = 4'h3;
  localparam logic [3:0] ROLE_ATTACH_WAIT = 4'h6;
  localparam logic [3:0] ROLE_ATTACHED_CC2 = 4'h8;
  localparam logic [3:0] ROLE_ATTACHED_CC1 = 4'hC;
  localparam logic [7:0] PORT_STATE_RESET = 8'h00;
  localparam logic [7:0] MEAS_RESET = 8'h00;
  localparam logic [7:0] FREQ_CTRL_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    TSAR_TC_DISABLED = 3'b000,
    TSAR_TC_ERR_RECOV = 3'b001,
    TSAR_TC_UNATTACHED = 3'b010,
    TSAR_TC_ATTACH_WAIT = 3'b011,
    TSAR_TC_ATTACHED = 3'b100
  } tsar_tc_state_type;

  typedef struct packed {
    tsar_tc_state_type state;
    logic attached_cc2;
    logic rd_cc1;
    logic rd_cc2;
  } tsar_tc_status_type;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } tsar_adc_result_type;

  typedef enum logic [2:0] {
    TSAR_I2C_IDLE = 3'b000,
    TSAR_I2C_ADDR = 3'b001,
    TSAR_I2C_ACK = 3'b010,
    TSAR_I2C_WRITE = 3'b011,
    TSAR_I2C_READ = 3'b100,
    TSAR_I2C_RACK = 3'b101
  } tsar_i2c_state_type;
endpackage : tsar_pkg

// >>> logic/tsar_meas_reg.sv
// One read-only measurement result register
`timescale 1ns/1ps
`default_nettype none
module tsar_meas_reg
  import tsar_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire tsar_adc_result_type adc,
  output logic [7:0] q
);
  logic [7:0] q_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      q_ff <= MEAS_RESET;
    end else if (adc.valid) begin
      q_ff <= adc.code;
    end
  end

  assign q = q_ff;

  meas_load_a: assert property (@(posedge clk) disable iff (rst)
    adc.valid |=> q_ff == $past(adc.code))
    else $error("result not captured on conversion strobe");
  meas_hold_a: assert property (@(posedge clk) disable iff (rst)
    !adc.valid |=> $stable(q_ff))
    else $error("result changed without conversion strobe");
endmodule : tsar_meas_reg
`default_nettype wire

// >>> logic/tsar_readout_top.sv
// I2C register slave with port state, measurement results and frequency control
`timescale 1ns/1ps
`default_nettype none
module tsar_readout_top
  import tsar_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire tsar_tc_status_type tc_status,
  input wire tsar_adc_result_type load_current_adc,
  input wire tsar_adc_result_type bus_voltage_adc,
  input wire tsar_adc_result_type die_temp_adc,
  input wire logic [FREQ_W-1:0] strap_freq_code,
  output logic [FREQ_W-1:0] freq_setting,
  output logic freq_from_host
);
  tsar_i2c_state_type st_ff;
  logic scl_q_ff;
  logic sda_q_ff;
  logic [7:0] sh_ff;
  logic [7:0] tx_ff;
  logic [3:0] cnt_ff;
  logic [7:0] ptr_ff;
  logic rw_ff;
  logic got_ptr_ff;
  logic nack_ff;
  logic sda_out_ff;
  logic sda_oe_n_ff;
  logic [7:0] port_state_ff;
  logic [7:0] freq_ctrl_ff;
  logic [FREQ_W-1:0] strap_ff;
  logic strap_taken_ff;
  logic [FREQ_W-1:0] freq_setting_ff;
  logic freq_from_host_ff;
  logic [7:0] load_current_result;
  logic [7:0] bus_voltage_result;
  logic [7:0] die_temp_result;

  // Bus events; pins are synchronous to clk
  wire scl_rise = scl_in & ~scl_q_ff;
  wire scl_fall = ~scl_in & scl_q_ff;
  wire bus_start = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
  wire bus_stop = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
  wire byte_done = cnt_ff == BITS_PER_BYTE;
  wire addr_match = sh_ff[7:1] == DEV_ADDR;
  wire bus_edge_fall = scl_fall & ~bus_start & ~bus_stop;
  wire host_wr = bus_edge_fall & (st_ff == TSAR_I2C_WRITE) & byte_done & got_ptr_ff;
  wire freq_wr = host_wr & (ptr_ff == OFS_FREQ_CTRL);

  // Port state encoding
  wire [1:0] attach_orientation = tc_status.rd_cc1 ? ORIENT_CC1 :
                                  (tc_status.rd_cc2 ? ORIENT_CC2 : ORIENT_NONE);
  wire [3:0] port_role_state =
    (tc_status.state == TSAR_TC_ATTACHED) ?
      (tc_status.attached_cc2 ? ROLE_ATTACHED_CC2 : ROLE_ATTACHED_CC1) :
    (tc_status.state == TSAR_TC_ATTACH_WAIT) ? ROLE_ATTACH_WAIT :
    (tc_status.state == TSAR_TC_UNATTACHED) ? ROLE_UNATTACHED :
    (tc_status.state == TSAR_TC_ERR_RECOV) ? ROLE_ERR_RECOV : ROLE_DISABLED;
  wire [7:0] nxt_port_state = {2'h0, attach_orientation, port_role_state};

  // Read mux has no side effects on any register
  wire [7:0] rdata = (ptr_ff == OFS_PORT_STATE) ? port_state_ff :
                     (ptr_ff == OFS_LOAD_CURRENT) ? load_current_result :
                     (ptr_ff == OFS_BUS_VOLTAGE) ? bus_voltage_result :
                     (ptr_ff == OFS_DIE_TEMP) ? die_temp_result :
                     (ptr_ff == OFS_FREQ_CTRL) ? freq_ctrl_ff : UNMAPPED_READ;

  // Effective frequency: host value once enabled, strap otherwise
  wire [FREQ_W-1:0] nxt_freq_setting = freq_ctrl_ff[FREQ_OVR_BIT] ?
                                       freq_ctrl_ff[FREQ_W-1:0] : strap_ff;

  tsar_meas_reg u_load_current (
    .clk(clk),
    .rst(rst),
    .adc(load_current_adc),
    .q(load_current_result)
  );

  tsar_meas_reg u_bus_voltage (
    .clk(clk),
    .rst(rst),
    .adc(bus_voltage_adc),
    .q(bus_voltage_result)
  );

  tsar_meas_reg u_die_temp (
    .clk(clk),
    .rst(rst),
    .adc(die_temp_adc),
    .q(die_temp_result)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      port_state_ff <= PORT_STATE_RESET;
    end else begin
      scl_q_ff <= scl_in;
      sda_q_ff <= sda_in;
      port_state_ff <= nxt_port_state;
    end
  end

  // Strap is caught by the first clock after reset release
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_ff <= '0;
      strap_taken_ff <= 1'b0;
      freq_ctrl_ff <= FREQ_CTRL_RESET;
      freq_setting_ff <= '0;
      freq_from_host_ff <= 1'b0;
    end else begin
      if (!strap_taken_ff) begin
        strap_ff <= strap_freq_code;
        strap_taken_ff <= 1'b1;
      end
      if (freq_wr) begin
        freq_ctrl_ff <= sh_ff;
      end
      freq_setting_ff <= nxt_freq_setting;
      freq_from_host_ff <= freq_ctrl_ff[FREQ_OVR_BIT];
    end
  end

  // Slave sequencer: sda changes after scl falls, and is released at start and stop
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= TSAR_I2C_IDLE;
      sh_ff <= '0;
      tx_ff <= '0;
      cnt_ff <= '0;
      ptr_ff <= '0;
      rw_ff <= 1'b0;
      got_ptr_ff <= 1'b0;
      nack_ff <= 1'b0;
      sda_out_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
    end else if (bus_start) begin
      st_ff <= TSAR_I2C_ADDR;
      cnt_ff <= '0;
      got_ptr_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
    end else if (bus_stop) begin
      st_ff <= TSAR_I2C_IDLE;
      sda_oe_n_ff <= 1'b1;
    end else if (scl_rise) begin
      if (st_ff == TSAR_I2C_ADDR || st_ff == TSAR_I2C_WRITE) begin
        sh_ff <= {sh_ff[6:0], sda_in};
        cnt_ff <= cnt_ff + 4'h1;
      end
      if (st_ff == TSAR_I2C_RACK) begin
        nack_ff <= sda_in;
      end
    end else if (scl_fall) begin
      unique case (st_ff)
        TSAR_I2C_IDLE: begin
        end
        TSAR_I2C_ADDR: begin
          if (byte_done) begin
            if (addr_match) begin
              st_ff <= TSAR_I2C_ACK;
              sda_oe_n_ff <= 1'b0;
              rw_ff <= sh_ff[0];
            end else begin
              st_ff <= TSAR_I2C_IDLE;
            end
          end
        end
        TSAR_I2C_WRITE: begin
          if (byte_done) begin
            st_ff <= TSAR_I2C_ACK;
            sda_oe_n_ff <= 1'b0;
            if (!got_ptr_ff) begin
              ptr_ff <= sh_ff;
              got_ptr_ff <= 1'b1;
            end else begin
              ptr_ff <= ptr_ff + 8'h01;
            end
          end
        end
        TSAR_I2C_ACK, TSAR_I2C_RACK: begin
          if (st_ff == TSAR_I2C_RACK && nack_ff) begin
            st_ff <= TSAR_I2C_IDLE;
            sda_oe_n_ff <= 1'b1;
          end else if (rw_ff) begin
            tx_ff <= {rdata[6:0], 1'b0};
            sda_oe_n_ff <= rdata[7];
            ptr_ff <= ptr_ff + 8'h01;
            cnt_ff <= 4'h1;
            st_ff <= TSAR_I2C_READ;
          end else begin
            sda_oe_n_ff <= 1'b1;
            cnt_ff <= '0;
            st_ff <= TSAR_I2C_WRITE;
          end
        end
        TSAR_I2C_READ: begin
          if (byte_done) begin
            sda_oe_n_ff <= 1'b1;
            st_ff <= TSAR_I2C_RACK;
          end else begin
            sda_oe_n_ff <= tx_ff[7];
            tx_ff <= {tx_ff[6:0], 1'b0};
            cnt_ff <= cnt_ff + 4'h1;
          end
        end
        default: begin
          st_ff <= TSAR_I2C_IDLE;
          sda_oe_n_ff <= 1'b1;
        end
      endcase
    end
  end

  assign sda_out = sda_out_ff;
  assign sda_oe_n = sda_oe_n_ff;
  assign freq_setting = freq_setting_ff;
  assign freq_from_host = freq_from_host_ff;

  orient_never_three_a: assert property (@(posedge clk) disable iff (rst)
    port_state_ff[5:4] != 2'b11)
    else $error("orientation field shows unused code");
  orient_cc2_a: assert property (@(posedge clk) disable iff (rst)
    (tc_status.rd_cc2 && !tc_status.rd_cc1) |=> port_state_ff[5:4] == 2'b10)
    else $error("CC2 orientation not reported");
  role_wait_a: assert property (@(posedge clk) disable iff (rst)
    tc_status.state == TSAR_TC_ATTACH_WAIT |=> port_state_ff[3:0] == 4'h6)
    else $error("attach wait not reported");
  role_attached_a: assert property (@(posedge clk) disable iff (rst)
    tc_status.state == TSAR_TC_ATTACHED |=>
      port_state_ff[3:0] == ($past(tc_status.attached_cc2) ? 4'h8 : 4'hC))
    else $error("attached state code wrong for orientation");
  freq_source_a: assert property (@(posedge clk) disable iff (rst)
    (strap_taken_ff && !freq_ctrl_ff[FREQ_OVR_BIT]) |=> freq_setting_ff == $past(strap_ff))
    else $error("strap frequency not applied");
  freq_write_a: assert property (@(posedge clk) disable iff (rst)
    freq_wr ##1 freq_ctrl_ff[FREQ_OVR_BIT] |=> freq_setting_ff == $past(freq_ctrl_ff[3:0], 1))
    else $error("host frequency not applied");
  ro_write_ignored_a: assert property (@(posedge clk) disable iff (rst)
    (host_wr && ptr_ff != OFS_FREQ_CTRL) |=> $stable(freq_ctrl_ff))
    else $error("write to read-only offset changed control");
  read_no_effect_a: assert property (@(posedge clk) disable iff (rst)
    (st_ff == TSAR_I2C_READ) |=> $stable(freq_ctrl_ff) && $stable(strap_ff))
    else $error("read changed register state");
endmodule : tsar_readout_top
`default_nettype wire

// >>> bench/tsar_i2c_host.sv
// Host processor model that masters the I2C lines of the readout block
`timescale 1ns/1ps
`default_nettype none
module tsar_i2c_host #(
  parameter logic [6:0] DEV_ADDR = 7'h00
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_h,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // SDA falls while SCL is high; also serves as repeated start
  task automatic start_c;
    sda_h <= 1'b1;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_h <= 1'b0;
    tick(3);
    scl <= 1'b0;
    tick(3);
  endtask : start_c
  task automatic stop_c;
    sda_h <= 1'b0;
    tick(3);
    scl <= 1'b1;
    tick(3);
    sda_h <= 1'b1;
    tick(3);
  endtask : stop_c
  // Eight bits MSB first, then the acknowledge bit; SDA moves only while SCL is low
  task automatic xfer(input logic [7:0] d, input logic m_ack, output logic [7:0] r,
                      output logic ack_n);
    for (int i = 7; i >= -1; i--) begin
      sda_h <= (i < 0) ? m_ack : d[i[2:0]];
      tick(3);
      scl <= 1'b1;
      tick(2);
      if (i >= 0) r[i[2:0]] = sda_line;
      else ack_n = sda_line;
      tick(1);
      scl <= 1'b0;
      tick(1);
    end
  endtask : xfer
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                           output logic ack_n);
    logic [7:0] r;
    logic a;
    start_c();
    xfer({dev, 1'b0}, 1'b1, r, ack_n);
    xfer(ptr, 1'b1, r, a);
    xfer(d, 1'b1, r, a);
    stop_c();
  endtask : write_reg
  task automatic read_reg(input logic [7:0] ptr);
    logic [7:0] r;
    logic a;
    start_c();
    xfer({DEV_ADDR, 1'b0}, 1'b1, r, a);
    xfer(ptr, 1'b1, r, a);
    start_c();
    xfer({DEV_ADDR, 1'b1}, 1'b1, r, a);
    // Host NACK ends the read
    xfer(8'hFF, 1'b1, r, a);
    stop_c();
    rd_data <= r;
    rd_valid <= 1'b1;
    tick(1);
    rd_valid <= 1'b0;
  endtask : read_reg
endmodule : tsar_i2c_host
`default_nettype wire

// >>> bench/tsar_readout_top_tb_top.sv
// Testbench of the readout block with host model and scoreboard queue
`timescale 1ns/1ps
`default_nettype none
module tsar_readout_top_tb_top;
  import tsar_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_h, sda_out, sda_oe_n, sda_line, rd_valid, freq_from_host, ack_n;
  logic [7:0] rd_data;
  logic [FREQ_W-1:0] strap = 4'h0, freq_setting, fc;
  tsar_tc_status_type tc = '0;
  tsar_adc_result_type adc [3] = '{default: '0};
  logic [7:0] exp_q [$];
  logic [7:0] code [3];
  logic [31:0] seed = 32'h0000505C;
  logic [31:0] rnd;
  int err_count = 0, num_checks = 0, cycles = 0;
  logic [7:0] ofs [4] = '{OFS_PORT_STATE, OFS_LOAD_CURRENT, OFS_BUS_VOLTAGE, OFS_DIE_TEMP};
  logic [5:0] tcv [7] = '{6'h00, 6'h08, 6'h11, 6'h1A, 6'h22, 6'h25, 6'h23};
  logic [7:0] tce [7] = '{8'h00, 8'h02, 8'h23, 8'h16, 8'h1C, 8'h28, 8'h1C};
  // Open-drain SDA with pull-up
  assign sda_line = sda_h & (sda_oe_n | sda_out);
  always #25 clk = ~clk;
  tsar_readout_top tsar_readout_top_inst (.clk(clk), .rst(rst), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .tc_status(tc),
    .load_current_adc(adc[0]), .bus_voltage_adc(adc[1]), .die_temp_adc(adc[2]),
    .strap_freq_code(strap), .freq_setting(freq_setting), .freq_from_host(freq_from_host));
  tsar_i2c_host #(.DEV_ADDR(DEV_ADDR_DEFAULT)) tsar_i2c_host_inst (.clk(clk),
    .sda_line(sda_line), .scl(scl), .sda_h(sda_h), .rd_valid(rd_valid), .rd_data(rd_data));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic chk_freq(input logic [4:0] exp);
    chk("freq", {3'h0, exp}, {3'h0, freq_from_host, freq_setting});
  endtask : chk_freq
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    exp_q.push_back(exp);
    tsar_i2c_host_inst.read_reg(ptr);
  endtask : rd
  task automatic tally_and_finish;
    // Expectations never answered by a read add one mismatch in total, whatever their number
    if (exp_q.size() != 0) err_count++;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // Scoreboard: each finished host read takes the oldest expectation
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("queue", 8'hEE, rd_data);
      else chk("read", exp_q.pop_front(), rd_data);
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      tally_and_finish();
    end
  end
  initial begin
    rnd = xs();
    strap <= rnd[3:0];
    tick(10);
    rst <= 1'b0;
    tick(3);
    chk_freq({1'b0, strap});
    for (int i = 0; i < 4; i++) rd(ofs[i], 8'h00);
    for (int i = 0; i < 7; i++) begin
      tc <= tsar_tc_status_type'(tcv[i]);
      tick(2);
      rd(OFS_PORT_STATE, tce[i]);
    end
    for (int k = 0; k < 3; k++) begin
      rnd = xs();
      code[k] = rnd[7:0];
    end
    for (int k = 0; k < 3; k++) adc[k] <= {1'b1, code[k]};
    tick(1);
    // Code moves without valid; registers must hold
    for (int k = 0; k < 3; k++) adc[k] <= {1'b0, ~code[k]};
    for (int rep = 0; rep < 2; rep++) begin
      for (int k = 0; k < 3; k++) begin
        if (rep == 1) begin
          tsar_i2c_host_inst.write_reg(DEV_ADDR_DEFAULT, ofs[k + 1], ~code[k], ack_n);
          chk("write ack", 8'h00, {7'h00, ack_n});
        end
        rd(ofs[k + 1], code[k]);
      end
    end
    rd(8'h30, UNMAPPED_READ);
    // Host must keep this code out of the AM band; the code-to-frequency map lies outside
    rnd = xs();
    fc = rnd[3:0];
    tsar_i2c_host_inst.write_reg(DEV_ADDR_DEFAULT, OFS_FREQ_CTRL, {4'h8, fc}, ack_n);
    tick(3);
    chk_freq({1'b1, fc});
    tsar_i2c_host_inst.write_reg(DEV_ADDR_DEFAULT ^ 7'h01, OFS_FREQ_CTRL, 8'h00, ack_n);
    tick(3);
    chk("nack", 8'h01, {7'h00, ack_n});
    chk_freq({1'b1, fc});
    tsar_i2c_host_inst.write_reg(DEV_ADDR_DEFAULT, OFS_FREQ_CTRL, 8'h00, ack_n);
    tick(3);
    chk_freq({1'b0, strap});
    tick(5);
    tally_and_finish();
  end
endmodule : tsar_readout_top_tb_top
`default_nettype wire
